// ===== rtl/limits_cfg_pkg.sv
// Constants for the output-stage and limits configuration registers.
// Function
// R1: Upper nibble selects one to eight drive modules.
// R2: Restart enable chooses stay-off or power-up after shutdown.
// R3: Register reset loads reset flag with one.
// R4: Host writes zero to reset flag afterward.
// R5: Warning field selects 83, 94, 105, 116 C.
// R6: Current field selects 2.9, 3.4, 3.9 A.
// R7: Writing reset request restores all defaults.
package limits_cfg_pkg;
  localparam logic [7:0] DRIVE_STAGE_COUNT_CONFIG_ADDR = 8'h15;
  localparam logic [7:0] LIMITS_AND_RECOVERY_CONFIG_ADDR = 8'h16;
  localparam int STAGE_COUNT_LSB = 4;
  localparam int RESTART_BIT = 0;
  localparam int RESET_FLAG_BIT = 1;
  localparam int RESET_REQUEST_BIT = 2;
  localparam int WARNING_LSB = 4;
  localparam int CURRENT_LSB = 6;
  localparam logic [3:0] STAGE_COUNT_RESET = 4'h7;
  localparam logic [3:0] STAGE_CODE_MAX = 4'h7;
  localparam logic [1:0] WARNING_RESET = 2'h0;
  localparam logic [1:0] CURRENT_RESET = 2'h3;
  localparam logic RESTART_RESET = 1'b0;
  // Thresholds in degrees C and limits in units of 100 mA.
  localparam logic [6:0] WARN_83C = 7'd83;
  localparam logic [6:0] WARN_94C = 7'd94;
  localparam logic [6:0] WARN_105C = 7'd105;
  localparam logic [6:0] WARN_116C = 7'd116;
  localparam logic [5:0] ILIM_2A9 = 6'd29;
  localparam logic [5:0] ILIM_3A4 = 6'd34;
  localparam logic [5:0] ILIM_3A9 = 6'd39;
  typedef enum {POWER_RUN, POWER_OFF, POWER_RESTART} power_state_t;
endpackage

// ===== rtl/output_stage_limits_config.sv
// Register bank holding drive-stage count and limits/recovery settings.
`timescale 1ns/100ps
`default_nettype none
module output_stage_limits_config
  import limits_cfg_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register access from the two-wire bus engine
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Thermal events from the analog monitor
  input wire logic thermal_shutdown,
  // Decoded settings
  output logic [3:0] drive_stage_count,
  output logic [6:0] thermal_warning_level,
  output logic [5:0] inductor_current_limit,
  output logic thermal_restart_enable,
  output logic register_reset_flag,
  output logic power_enable,
  output logic powerup_start
);
  logic [3:0] stage_code_q;
  logic [1:0] warn_code_q;
  logic [1:0] curr_code_q;
  logic restart_q;
  logic flag_q;
  logic force_q;
  logic tsd_s1_q;
  logic tsd_s2_q;
  logic tsd_prev_q;
  logic tsd_rise;
  logic wr_mod;
  logic wr_lim;
  power_state_t pstate_q;

  // Writes to any other address are dropped; the bank has no error response.
  assign wr_mod = reg_wr && reg_addr == DRIVE_STAGE_COUNT_CONFIG_ADDR;
  assign wr_lim = reg_wr && reg_addr == LIMITS_AND_RECOVERY_CONFIG_ADDR;
  // Only the rising edge of shutdown leaves the run state, so a long event counts once.
  assign tsd_rise = tsd_s2_q && !tsd_prev_q;

  // The shutdown flag comes from the analog side, so it is synchronised first.
  always_ff @(posedge mclk) begin
    if (rst) begin
      tsd_s1_q <= 1'b0;
      tsd_s2_q <= 1'b0;
      tsd_prev_q <= 1'b0;
    end else begin
      tsd_s1_q <= thermal_shutdown;
      tsd_s2_q <= tsd_s1_q;
      tsd_prev_q <= tsd_s2_q;
    end
  end

  // A forced reset takes effect one cycle after the write, so the request bit
  // reads 1 for that single cycle and then returns to its default.
  always_ff @(posedge mclk) begin
    if (rst || force_q) begin
      stage_code_q <= STAGE_COUNT_RESET;
      warn_code_q <= WARNING_RESET;
      curr_code_q <= CURRENT_RESET;
      restart_q <= RESTART_RESET;
      flag_q <= 1'b1; // R3 R7
      force_q <= 1'b0;
    end else begin
      if (wr_mod) begin
        stage_code_q <= reg_wdata[STAGE_COUNT_LSB +: 4];
      end
      if (wr_lim) begin
        curr_code_q <= reg_wdata[CURRENT_LSB +: 2];
        warn_code_q <= reg_wdata[WARNING_LSB +: 2];
        restart_q <= reg_wdata[RESTART_BIT];
        flag_q <= reg_wdata[RESET_FLAG_BIT]; // R4
        force_q <= reg_wdata[RESET_REQUEST_BIT]; // R7
      end
    end
  end

  // Restart keeps the programmed values; only a register reset clears them.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pstate_q <= POWER_RUN;
    end else begin
      case (pstate_q)
        POWER_RUN: begin
          if (tsd_rise) begin
            pstate_q <= restart_q ? POWER_RESTART : POWER_OFF; // R2
          end
        end
        POWER_RESTART: begin
          if (!tsd_s2_q) begin
            pstate_q <= POWER_RUN; // R2
          end
        end
        POWER_OFF: pstate_q <= POWER_OFF; // R2
        default: pstate_q <= POWER_RUN;
      endcase
    end
  end

  assign power_enable = pstate_q == POWER_RUN;
  assign powerup_start = pstate_q == POWER_RESTART && !tsd_s2_q;

  // Codes above seven saturate at eight modules instead of wrapping to fewer.
  always_comb begin
    if (stage_code_q >= STAGE_CODE_MAX) begin
      drive_stage_count = 4'h8; // R1
    end else begin
      drive_stage_count = stage_code_q + 4'h1; // R1
    end
    case (warn_code_q)
      2'h0: thermal_warning_level = WARN_83C; // R5
      2'h1: thermal_warning_level = WARN_94C;
      2'h2: thermal_warning_level = WARN_105C;
      default: thermal_warning_level = WARN_116C;
    endcase
    case (curr_code_q)
      2'h2: inductor_current_limit = ILIM_3A4; // R6
      2'h3: inductor_current_limit = ILIM_3A9;
      default: inductor_current_limit = ILIM_2A9;
    endcase
  end

  assign thermal_restart_enable = restart_q;
  assign register_reset_flag = flag_q;

  // Spare bits and unmapped addresses read as zero; reads need no strobe.
  always_comb begin
    case (reg_addr)
      DRIVE_STAGE_COUNT_CONFIG_ADDR: reg_rdata = {stage_code_q, 4'h0};
      LIMITS_AND_RECOVERY_CONFIG_ADDR:
        reg_rdata = {curr_code_q, warn_code_q, 1'b0, force_q, flag_q, restart_q};
      default: reg_rdata = 8'h00;
    endcase
  end

  property p_force_reset;
    @(posedge mclk) disable iff (rst)
      wr_lim && reg_wdata[RESET_REQUEST_BIT] && !force_q
        |-> ##2 flag_q && stage_code_q == STAGE_COUNT_RESET;
  endproperty
  a_force_reset: assert property (p_force_reset) else $error("forced reset failed"); // R7
  property p_flag_clear;
    @(posedge mclk) disable iff (rst)
      wr_lim && !reg_wdata[RESET_FLAG_BIT] && !reg_wdata[RESET_REQUEST_BIT] && !force_q
        |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // R4
  property p_flag_set;
    @(posedge mclk) force_q |=> flag_q && restart_q == RESTART_RESET;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by reset"); // R3
  property p_stages;
    @(posedge mclk) disable iff (rst)
      stage_code_q < STAGE_CODE_MAX |-> drive_stage_count == stage_code_q + 4'h1;
  endproperty
  a_stages: assert property (p_stages) else $error("stage count wrong"); // R1
  property p_stage_sat;
    @(posedge mclk) stage_code_q >= STAGE_CODE_MAX |-> drive_stage_count == 4'h8;
  endproperty
  a_stage_sat: assert property (p_stage_sat) else $error("stage count not saturated"); // R1
  property p_stay_off;
    @(posedge mclk) disable iff (rst)
      pstate_q == POWER_RUN && tsd_rise && !restart_q |=> !power_enable [*4];
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("restarted while disarmed"); // R2
  property p_thermal_restart_enable;
    @(posedge mclk) disable iff (rst)
      pstate_q == POWER_RESTART && !tsd_s2_q |-> powerup_start ##1 power_enable;
  endproperty
  a_thermal_restart_enable: assert property (p_thermal_restart_enable) else $error("no power-up after shutdown"); // R2
  property p_warn;
    @(posedge mclk) warn_code_q == 2'h2 |-> thermal_warning_level == WARN_105C;
  endproperty
  a_warn: assert property (p_warn) else $error("warning level wrong"); // R5
  property p_curr;
    @(posedge mclk) curr_code_q == 2'h1 |-> inductor_current_limit == ILIM_2A9;
  endproperty
  a_curr: assert property (p_curr) else $error("current limit wrong"); // R6
  // Every code of both decoded fields is pinned down, not just one sample of each.
  property p_warn_83;
    @(posedge mclk) warn_code_q == 2'h0 |-> thermal_warning_level == WARN_83C;
  endproperty
  a_warn_83: assert property (p_warn_83) else $error("warning level wrong"); // R5
  property p_warn_94;
    @(posedge mclk) warn_code_q == 2'h1 |-> thermal_warning_level == WARN_94C;
  endproperty
  a_warn_94: assert property (p_warn_94) else $error("warning level wrong"); // R5
  property p_warn_116;
    @(posedge mclk) warn_code_q == 2'h3 |-> thermal_warning_level == WARN_116C;
  endproperty
  a_warn_116: assert property (p_warn_116) else $error("warning level wrong"); // R5
  property p_curr_low;
    @(posedge mclk) curr_code_q == 2'h0 |-> inductor_current_limit == ILIM_2A9;
  endproperty
  a_curr_low: assert property (p_curr_low) else $error("current limit wrong"); // R6
  property p_curr_mid;
    @(posedge mclk) curr_code_q == 2'h2 |-> inductor_current_limit == ILIM_3A4;
  endproperty
  a_curr_mid: assert property (p_curr_mid) else $error("current limit wrong"); // R6
  property p_curr_high;
    @(posedge mclk) curr_code_q == 2'h3 |-> inductor_current_limit == ILIM_3A9;
  endproperty
  a_curr_high: assert property (p_curr_high) else $error("current limit wrong"); // R6
  // A thermal event must not touch the programmed settings; only a write or reset may.
  property p_keep_settings;
    @(posedge mclk) disable iff (rst)
      pstate_q != POWER_RUN && !wr_mod && !wr_lim && !force_q
        |=> $stable(stage_code_q) && $stable(curr_code_q) && $stable(restart_q);
  endproperty
  a_keep_settings: assert property (p_keep_settings) else $error("settings lost"); // R2
  // A register reset, from the pin or from the request bit, always raises the flag.
  property p_reset_flag;
    @(posedge mclk) rst |=> flag_q && !force_q && stage_code_q == STAGE_COUNT_RESET;
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset did not load defaults"); // R3
  property p_request_pulse;
    @(posedge mclk) disable iff (rst)
      wr_lim && reg_wdata[RESET_REQUEST_BIT] && !force_q |=> force_q ##1 !force_q;
  endproperty
  a_request_pulse: assert property (p_request_pulse) else $error("request stuck"); // R7
  c_force: cover property (@(posedge mclk) wr_lim && reg_wdata[RESET_REQUEST_BIT]);
  c_restart: cover property (@(posedge mclk) powerup_start);
  c_off: cover property (@(posedge mclk) pstate_q == POWER_OFF);
  c_flag_clear: cover property (@(posedge mclk) wr_lim && !reg_wdata[RESET_FLAG_BIT]);
  c_stage_sat: cover property (@(posedge mclk) stage_code_q > STAGE_CODE_MAX);
endmodule
`default_nettype wire

// ===== verif/host_bus_model.sv
// Host-side model issuing register writes and reads.
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
  // Clock
  input wire logic mclk,
  // Register access
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Data is inverted after a write so a stale byte never passes for a fresh one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 reg_addr = a;
    @(posedge mclk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_output_stage_limits_config.sv
// Self-checking bench for the drive-stage and limits register bank.
`timescale 1ns/100ps
`default_nettype none
module tb_output_stage_limits_config;
  logic mclk, rst, reg_wr, thermal_shutdown, power_enable, powerup_start;
  logic register_reset_flag, thermal_restart_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] drive_stage_count;
  logic [6:0] thermal_warning_level;
  logic [5:0] inductor_current_limit;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  output_stage_limits_config output_stage_limits_config_i (.mclk(mclk), .rst(rst),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .thermal_shutdown(thermal_shutdown), .drive_stage_count(drive_stage_count),
    .thermal_warning_level(thermal_warning_level),
    .inductor_current_limit(inductor_current_limit),
    .thermal_restart_enable(thermal_restart_enable),
    .register_reset_flag(register_reset_flag), .power_enable(power_enable),
    .powerup_start(powerup_start));
  host_bus_model host_bus_model_i (.mclk(mclk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic regchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_bus_model_i.rd(a, d);
    chk(d, exp);
  endtask
  task automatic test_done;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // The wait after shutdown is released is capped at 12 cycles so a missing restart is seen as a timeout.
  task automatic trip(input logic [7:0] cfg);
    int n;
    host_bus_model_i.wr(8'h16, cfg);
    chk(thermal_restart_enable, cfg[0]);
    thermal_shutdown = 1'b1;
    repeat (5) @(posedge mclk);
    #1 chk(power_enable, 8'h00);
    thermal_shutdown = 1'b0;
    n = 0;
    while (powerup_start !== 1'b1 && n < 12) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(n < 12, cfg[0]);
    @(posedge mclk);
    #1 chk(power_enable, cfg[0]);
    chk(powerup_start, 8'h00);
    regchk(8'h16, cfg);
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 2000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    rst = 1'b1;
    thermal_shutdown = 1'b0;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    regchk(8'h15, 8'h70);
    regchk(8'h16, 8'hc2);
    for (int i = 0; i < 16; i++) begin
      host_bus_model_i.wr(8'h15, 8'(i << 4));
      regchk(8'h15, 8'(i << 4));
      chk(drive_stage_count, (i > 7) ? 8'h08 : 8'(i + 1));
    end
    for (int i = 0; i < 4; i++) begin
      host_bus_model_i.wr(8'h16, {i[1:0], i[1:0], 4'h0});
      chk(register_reset_flag, 8'h00);
      chk(thermal_warning_level, 8'(83 + 11 * i));
      chk(inductor_current_limit, (i < 2) ? 8'h1d : 8'(29 + 5 * (i - 1)));
    end
    host_bus_model_i.wr(8'h17, 8'hff);
    regchk(8'h17, 8'h00);
    regchk(8'h15, 8'hf0);
    host_bus_model_i.wr(8'h16, 8'h04);
    chk(reg_rdata, 8'h04);
    repeat (2) @(posedge mclk);
    regchk(8'h16, 8'hc2);
    regchk(8'h15, 8'h70);
    chk(register_reset_flag, 8'h01);
    trip(8'h01);
    trip(8'h00);
    @(posedge mclk);
    #1 rst = 1'b1;
    @(posedge mclk);
    #1 rst = 1'b0;
    chk(power_enable, 8'h01);
    chk(register_reset_flag, 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
